// ---- rtl/uhcrb_bringup.sv ----
// Clock, reset and reference bring-up for the full/low-speed host controller
`timescale 1ns/1ps
module uhcrb_bringup
  import uhcrb_pkg::*;
#(
  parameter int INIT_CYCLES = UHCRB_INIT_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        lpsc_clk_en,
  input  wire logic        lpsc_rst_release,
  input  wire logic        ref_src_sel,
  input  wire logic        hs_phy_ready,
  input  wire logic        hs_phy_ref_clk,
  input  wire logic        external_ref_clock_pin,
  input  wire logic        hc_irq_raw,
  input  wire logic [31:0] hc_rev_value,
  input  wire logic [31:0] hc_hcca_value,
  output logic             ctrl_clk_gate_en,
  output logic             ctrl_rst_b,
  output logic             phy_enable,
  output logic             ref_ok,
  output logic             init_done,
  output logic [31:0]      revision_number_register,
  output logic [31:0]      comm_area_base_register,
  output logic             irq_to_cpu0,
  output logic             irq_to_cpu1
);

  // Shift one stage toward the core clock; shared by every async input
  function automatic logic [1:0] uhcrb_sync_step(
    input logic [1:0] stages,
    input logic       din
  );
    return {stages[0], din};
  endfunction

  // Core sees its reset lifted only in these two states
  function automatic logic uhcrb_core_free(
    input uhcrb_state_t st
  );
    return (st == UHCRB_ST_INIT) || (st == UHCRB_ST_READY);
  endfunction

  // Two-flop synchronisers for the sleep-module pair, the source select, phy ready and the two reference sources
  logic [1:0] en_s_q, rel_s_q, sel_s_q, phy_s_q, hsref_s_q, pinref_s_q;
  logic [1:0] en_s_d, rel_s_d, sel_s_d, phy_s_d, hsref_s_d, pinref_s_d;

  // Stage one may go metastable, so only stage two is ever read
  always_comb begin
    en_s_d     = uhcrb_sync_step(en_s_q, lpsc_clk_en);
    rel_s_d    = uhcrb_sync_step(rel_s_q, lpsc_rst_release);
    sel_s_d    = uhcrb_sync_step(sel_s_q, ref_src_sel);
    phy_s_d    = uhcrb_sync_step(phy_s_q, hs_phy_ready);
    hsref_s_d  = uhcrb_sync_step(hsref_s_q, hs_phy_ref_clk);
    pinref_s_d = uhcrb_sync_step(pinref_s_q, external_ref_clock_pin);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      en_s_q     <= 2'h0;
      rel_s_q    <= 2'h0;
      sel_s_q    <= 2'h0;
      phy_s_q    <= 2'h0;
      hsref_s_q  <= 2'h0;
      pinref_s_q <= 2'h0;
    end else begin
      en_s_q     <= en_s_d;
      rel_s_q    <= rel_s_d;
      sel_s_q    <= sel_s_d;
      phy_s_q    <= phy_s_d;
      hsref_s_q  <= hsref_s_d;
      pinref_s_q <= pinref_s_d;
    end
  end

  logic clk_en_s, rel_s, sel_s, phy_rdy_s, ref_sel_s, ref_alive;
  assign clk_en_s  = en_s_q[1];
  assign rel_s     = rel_s_q[1];
  assign sel_s     = sel_s_q[1];
  assign phy_rdy_s = phy_s_q[1];

  // Source mux after synchronisation, so a switch never glitches a flop
  assign ref_sel_s = (sel_s == UHCRB_SRC_PIN) ? pinref_s_q[1] : hsref_s_q[1]; // RULE9

  uhcrb_ref_mon u_ref_mon (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .ref_sync  (ref_sel_s),
    .ref_alive (ref_alive)
  );

  // After a source switch the monitor still holds the old count; distrust it
  // for two full windows rather than report a clock that is not there
  logic       sel_prev_q, sel_prev_d;
  logic [7:0] hold_q, hold_d;
  always_comb begin
    sel_prev_d = sel_s;
    hold_d     = hold_q;
    if (sel_s != sel_prev_q) begin
      hold_d = 8'(2 * UHCRB_REF_WINDOW_CYCLES - 1); // RULE9
    end else if (hold_q != 8'h00) begin
      hold_d = hold_q - 8'h01;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_prev_q <= 1'b0;
      hold_q     <= 8'h00;
    end else begin
      sel_prev_q <= sel_prev_d;
      hold_q     <= hold_d;
    end
  end

  // Reference usable only when the chosen source is really up
  logic ref_ok_q, ref_ok_d;
  always_comb begin
    ref_ok_d = ref_alive;
    if (sel_s == UHCRB_SRC_HS_PHY) begin
      ref_ok_d = ref_alive && phy_rdy_s; // RULE9
    end
    if (hold_q != 8'h00 || sel_s != sel_prev_q) begin
      ref_ok_d = 1'b0; // RULE8
    end
  end

  // Bring-up sequencer; device reset lands in HELD
  uhcrb_state_t st_q, st_d;
  logic [15:0]  cnt_q, cnt_d;
  logic         en_prev_q;
  logic         en_rise;
  assign en_rise = clk_en_s && !en_prev_q;

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    case (st_q)
      UHCRB_ST_HELD: begin
        // Release only counts once a gated-off to on edge was seen
        if (en_rise && !rel_s) begin
          st_d = UHCRB_ST_GATED; // RULE10
        end
      end
      UHCRB_ST_GATED: begin
        if (!clk_en_s) begin
          st_d = UHCRB_ST_HELD;
        end else if (rel_s) begin
          st_d = UHCRB_ST_ARMED; // RULE5
        end
      end
      UHCRB_ST_ARMED: begin
        cnt_d = 16'h0000;
        st_d  = UHCRB_ST_INIT;
      end
      UHCRB_ST_INIT: begin
        cnt_d = cnt_q + 16'h0001;
        if (cnt_q >= 16'(INIT_CYCLES - 1)) begin
          st_d = UHCRB_ST_READY; // RULE10
        end
      end
      UHCRB_ST_READY: begin
        st_d = st_q;
      end
      default: begin
        st_d = UHCRB_ST_HELD;
      end
    endcase
    // Clock loss drops all the way back; the enable edge must be seen again
    if (st_q != UHCRB_ST_HELD && !clk_en_s) begin
      st_d  = UHCRB_ST_HELD; // RULE10
      cnt_d = 16'h0000;
    end else if (!rel_s && (st_q == UHCRB_ST_ARMED || uhcrb_core_free(st_q))) begin
      // Software reset with the clock still on: reinit on the next release
      st_d  = UHCRB_ST_GATED; // RULE6
      cnt_d = 16'h0000;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q      <= UHCRB_ST_HELD; // RULE5
      cnt_q     <= 16'h0000;
      en_prev_q <= 1'b0;
      ref_ok_q  <= 1'b0;
    end else begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      en_prev_q <= clk_en_s;
      ref_ok_q  <= ref_ok_d;
    end
  end

  // Registered outputs toward the controller core and software view
  logic        gate_q, gate_d, crst_q, crst_d, phy_q, phy_d, done_q, done_d;
  logic [31:0] rev_q, rev_d, hcca_q, hcca_d;
  logic        irq0_q, irq1_q, irq_d;

  always_comb begin
    // Both gate and reset steered by one local sleep module input pair
    gate_d = clk_en_s; // RULE4 RULE7
    crst_d = uhcrb_core_free(st_q); // RULE7
    done_d = (st_q == UHCRB_ST_READY); // RULE10
    // Phy runs only with a live reference; one port, FS/LS
    phy_d  = done_d && ref_ok_q; // RULE8 RULE1
    // Non-default values until reset completes, usable as a poll flag
    rev_d  = done_d ? hc_rev_value : UHCRB_BUSY_PATTERN; // RULE13
    hcca_d = done_d ? hc_hcca_value : UHCRB_BUSY_PATTERN; // RULE13
    // Core masters its own memory; only drop its request while in reset
    irq_d  = done_d && gate_q && hc_irq_raw; // RULE2
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gate_q <= 1'b0;
      crst_q <= 1'b0;
      phy_q  <= 1'b0;
      done_q <= 1'b0;
      rev_q  <= UHCRB_BUSY_PATTERN;
      hcca_q <= UHCRB_BUSY_PATTERN;
      irq0_q <= 1'b0;
      irq1_q <= 1'b0;
    end else begin
      gate_q <= gate_d;
      crst_q <= crst_d;
      phy_q  <= phy_d;
      done_q <= done_d;
      rev_q  <= rev_d;
      hcca_q <= hcca_d;
      irq0_q <= irq_d; // RULE3
      irq1_q <= irq_d; // RULE3
    end
  end

  assign ctrl_clk_gate_en         = gate_q;
  assign ctrl_rst_b               = crst_q;
  assign phy_enable               = phy_q;
  assign ref_ok                   = ref_ok_q;
  assign init_done                = done_q;
  assign revision_number_register = rev_q;
  assign comm_area_base_register  = hcca_q;
  assign irq_to_cpu0              = irq0_q;
  assign irq_to_cpu1              = irq1_q;

endmodule // uhcrb_bringup

// ---- rtl/uhcrb_pkg.sv ----
// Package of constants and types for the USB host clock/reset bring-up block
// Functional notes
// (RULE1) One downstream port, low and full speed
// (RULE2) Descriptors fetched by own bus master
// (RULE3) Interrupt goes to both host processors
// (RULE4) Logic runs on gated peripheral bus clock
// (RULE5) Local reset held from device reset until released
// (RULE6) Software local reset reinitialises only this controller
// (RULE7) One local sleep module drives gate and reset
// (RULE8) Phy runs only with 48 MHz reference
// (RULE9) Reference from high-speed phy PLL or pin
// (RULE10) Internal reset ends after clock on, reset off
// (RULE11) Software polls two registers for default values
// (RULE12) System bus, local and reference clocks running
// (RULE13) Registers read non-default until reset completes
package uhcrb_pkg;

  // Speed grades served on the single port
  localparam int UHCRB_LS_RATE_BPS = 1500000;
  localparam int UHCRB_FS_RATE_BPS = 12000000;

  // Reference clock nominal rate and core clock period
  localparam int UHCRB_REF_CLK_MHZ = 48;
  localparam int UHCRB_CORE_PERIOD_PS = 5000;

  // Internal reset stretch after both conditions met, in ns and cycles
  localparam int UHCRB_INIT_TIME_NS = 100;
  localparam int UHCRB_INIT_CYCLES =
    (UHCRB_INIT_TIME_NS * 1000 + UHCRB_CORE_PERIOD_PS - 1) / UHCRB_CORE_PERIOD_PS;

  // Reference clock liveness: edges counted within a core window
  localparam int UHCRB_REF_WINDOW_CYCLES = 64;
  localparam int UHCRB_REF_MIN_EDGES = 4;

  // Register defaults after reset
  localparam logic [31:0] UHCRB_REV_DEFAULT = 32'h0000_0010;
  localparam logic [31:0] UHCRB_HCCA_DEFAULT = 32'h0000_0000;
  localparam logic [31:0] UHCRB_BUSY_PATTERN = 32'hffff_ffff;

  // Reference source select encoding
  localparam logic UHCRB_SRC_HS_PHY = 1'b0;
  localparam logic UHCRB_SRC_PIN = 1'b1;

  // Bring-up sequencer states, Gray along the usual path
  typedef enum logic [2:0] {
    UHCRB_ST_HELD  = 3'b000,
    UHCRB_ST_GATED = 3'b001,
    UHCRB_ST_ARMED = 3'b011,
    UHCRB_ST_INIT  = 3'b010,
    UHCRB_ST_READY = 3'b110
  } uhcrb_state_t;

endpackage

// ---- rtl/uhcrb_ref_mon.sv ----
// Reference clock liveness monitor for the selected 48 MHz source
`timescale 1ns/1ps
module uhcrb_ref_mon
  import uhcrb_pkg::*;
#(
  parameter int WINDOW    = UHCRB_REF_WINDOW_CYCLES,
  parameter int MIN_EDGES = UHCRB_REF_MIN_EDGES
) (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic ref_sync,
  output logic      ref_alive
);

  logic [7:0] win_q, win_d;
  logic [7:0] edges_q, edges_d;
  logic       prev_q, prev_d;
  logic       alive_q, alive_d;

  // Count rising edges of the synchronised reference per window
  always_comb begin
    prev_d  = ref_sync;
    win_d   = win_q + 8'h01;
    edges_d = edges_q;
    alive_d = alive_q;
    if (ref_sync && !prev_q) begin
      edges_d = edges_q + 8'h01;
    end
    if (win_q == 8'(WINDOW - 1)) begin
      win_d   = 8'h00;
      edges_d = 8'h00;
      alive_d = (edges_q >= 8'(MIN_EDGES)); // RULE8
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      win_q   <= 8'h00;
      edges_q <= 8'h00;
      prev_q  <= 1'b0;
      alive_q <= 1'b0;
    end else begin
      win_q   <= win_d;
      edges_q <= edges_d;
      prev_q  <= prev_d;
      alive_q <= alive_d;
    end
  end

  assign ref_alive = alive_q;

endmodule // uhcrb_ref_mon

// ---- tb/uhcrb_bringup_properties.sv ----
// Port-level checker for the bring-up block
`timescale 1ns/1ps
module uhcrb_bringup_chk
  import uhcrb_pkg::*;
#(
  parameter int INIT_CYCLES = UHCRB_INIT_CYCLES
) (
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        lpsc_clk_en,
  input wire logic        lpsc_rst_release,
  input wire logic        hc_irq_raw,
  input wire logic [31:0] hc_rev_value,
  input wire logic        ctrl_clk_gate_en,
  input wire logic        ctrl_rst_b,
  input wire logic        phy_enable,
  input wire logic        ref_ok,
  input wire logic        init_done,
  input wire logic [31:0] revision_number_register,
  input wire logic [31:0] comm_area_base_register,
  input wire logic        irq_to_cpu0,
  input wire logic        irq_to_cpu1
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  property p_irq_pair; irq_to_cpu0 == irq_to_cpu1; endproperty
  a_irq_pair: assert property (p_irq_pair) else $error("irq copies differ");
  property p_irq_fwd; init_done && hc_irq_raw ##1 init_done |-> irq_to_cpu0; endproperty
  a_irq_fwd: assert property (p_irq_fwd) else $error("irq not forwarded");
  property p_busy; !init_done |-> revision_number_register == UHCRB_BUSY_PATTERN
    && comm_area_base_register == UHCRB_BUSY_PATTERN; endproperty
  a_busy: assert property (p_busy) else $error("default shown early");
  property p_rev; init_done |-> revision_number_register == $past(hc_rev_value); endproperty
  a_rev: assert property (p_rev) else $error("revision not passed");
  property p_held; !lpsc_rst_release [*5] |-> !ctrl_rst_b && !init_done; endproperty
  a_held: assert property (p_held) else $error("reset not held");
  property p_gate; !lpsc_clk_en [*5] |-> !ctrl_clk_gate_en; endproperty
  a_gate: assert property (p_gate) else $error("clock not gated");
  property p_init; $rose(ctrl_rst_b) |-> ctrl_clk_gate_en && !init_done
    ##INIT_CYCLES init_done; endproperty
  a_init: assert property (p_init) else $error("init length wrong");
  property p_phy; phy_enable |-> ref_ok || $past(ref_ok); endproperty
  a_phy: assert property (p_phy) else $error("phy runs without ref");
  c_done: cover property ($rose(init_done));
  c_irq: cover property ($rose(irq_to_cpu1));
  c_ref: cover property ($fell(ref_ok));
endmodule // uhcrb_bringup_chk
bind uhcrb_bringup uhcrb_bringup_chk #(.INIT_CYCLES(INIT_CYCLES)) u_chk (.*);

// ---- tb/uhcrb_bringup_tb.sv ----
// Self-checking bench for the bring-up block
`timescale 1ns/1ps
module uhcrb_bringup_tb;
  import uhcrb_pkg::*;
  logic core_clk = 0, rst_b = 0, lpsc_clk_en = 0, lpsc_rst_release = 0, hs_phy_ready = 0;
  logic ref_src_sel = UHCRB_SRC_PIN, hc_irq_raw = 0, run_hs = 0, run_pin = 1;
  logic [31:0] hc_rev_value = UHCRB_REV_DEFAULT, hc_hcca_value = UHCRB_HCCA_DEFAULT;
  logic hs_phy_ref_clk, external_ref_clock_pin, ctrl_clk_gate_en, ctrl_rst_b;
  logic phy_enable, ref_ok, init_done, irq_to_cpu0, irq_to_cpu1;
  logic [31:0] revision_number_register, comm_area_base_register;
  int n_mismatch = 0, cmp_count = 0, cycles = 0;
  uhcrb_bringup #(.INIT_CYCLES(2)) u_dut (.*);
  uhcrb_ref_model u_ref (.*);
  always #2.5 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic drop();
    lpsc_rst_release = 0;
    lpsc_clk_en = 0;
    cyc(6);
  endtask
  // Enable, then release; done lands exactly 7 edges after release
  task automatic t_bringup();
    drop();
    lpsc_clk_en = 1;
    cyc(4);
    lpsc_rst_release = 1;
    cyc(6);
    chk(init_done, 0);
    chk(revision_number_register, UHCRB_BUSY_PATTERN);
    cyc(1);
    chk({ctrl_clk_gate_en, ctrl_rst_b, init_done}, 3'h7);
    chk(revision_number_register, UHCRB_REV_DEFAULT);
    chk(comm_area_base_register, UHCRB_HCCA_DEFAULT);
    $display("bringup test done");
  endtask
  task automatic t_irq();
    hc_irq_raw = 1;
    cyc(1);
    chk({irq_to_cpu0, irq_to_cpu1}, 2'h3);
    hc_irq_raw = 0;
    cyc(1);
    chk({irq_to_cpu0, irq_to_cpu1}, 2'h0);
    lpsc_rst_release = 0;
    cyc(4);
    chk({ctrl_rst_b, init_done}, 2'h0);
    hc_irq_raw = 1;
    cyc(2);
    chk({irq_to_cpu0, irq_to_cpu1}, 2'h0);
    hc_irq_raw = 0;
    lpsc_rst_release = 1;
    cyc(7);
    chk({ctrl_rst_b, init_done}, 2'h3);
    $display("irq and soft reset test done");
  endtask
  // Release before enable must never complete
  task automatic t_reverse();
    drop();
    lpsc_rst_release = 1;
    cyc(4);
    lpsc_clk_en = 1;
    cyc(40);
    chk({ctrl_rst_b, init_done}, 2'h0);
    $display("reverse order test done");
  endtask
  // Each source in turn; the phy path also needs the phy ready
  task automatic t_ref(input logic sel, input logic hs, input logic pin, input logic rdy,
                       input logic exp);
    ref_src_sel = sel;
    run_hs = hs;
    run_pin = pin;
    hs_phy_ready = rdy;
    cyc(140);
    chk(ref_ok, exp);
    chk(phy_enable, exp);
    $display("reference case done");
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    cyc(10);
    rst_b = 1;
    t_bringup();
    t_irq();
    t_reverse();
    t_bringup();
    t_ref(UHCRB_SRC_PIN, 0, 1, 0, 1);
    t_ref(UHCRB_SRC_PIN, 1, 0, 1, 0);
    t_ref(UHCRB_SRC_HS_PHY, 1, 0, 0, 0);
    t_ref(UHCRB_SRC_HS_PHY, 1, 0, 1, 1);
    summarize();
  end
endmodule // uhcrb_bringup_tb

// ---- tb/uhcrb_ref_model.sv ----
// Model of the two 48 MHz reference sources
`timescale 1ns/1ps
module uhcrb_ref_model (
  input  wire logic run_hs,
  input  wire logic run_pin,
  output logic      hs_phy_ref_clk,
  output logic      external_ref_clock_pin
);
  logic osc = 1'b0;
  // One oscillator; a stopped source idles low, never stale
  always #10.4 osc = ~osc;
  assign hs_phy_ref_clk         = run_hs & osc;
  assign external_ref_clock_pin = run_pin & osc;
endmodule // uhcrb_ref_model
